//--- logic/iag_pkg.sv
// Purpose: Constants and types for the interrupt acceptance gate.
// Assumes: One core clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses on AXI4-Lite.
package iag_pkg;
   // ==========================================
   // Register map
   localparam logic [3:0] IAG_OFS_STW = 4'h0;
   localparam logic [3:0] IAG_OFS_PEND = 4'h4;
   localparam logic [3:0] IAG_OFS_EVT_STAT = 4'h8;
   localparam logic [3:0] IAG_OFS_EVT_MASK = 4'hc;
   // ==========================================
   // Status word layout
   localparam int IAG_GIE_BIT = 15;
   localparam int IAG_FLAG_LSB = 8;
   localparam int IAG_NFLAGS = 6;
   localparam logic [15:0] IAG_STW_RST = 16'h0000;
   localparam logic [15:0] IAG_STW_WMASK = 16'hbfff;
   // ==========================================
   // Event status bits
   localparam int IAG_EVT_MACK = 0;
   localparam int IAG_EVT_NACK = 1;
   localparam int IAG_EVT_DIRECT = 2;
   localparam int IAG_NEVT = 3;
   localparam logic [1:0] IAG_RESP_OKAY = 2'b00;
   localparam logic [1:0] IAG_RESP_SLVERR = 2'b10;
   // ==========================================
   // Instruction classes reported at completion
   typedef enum logic [3:0] {
      IAG_CLS_PLAIN = 4'b0000,
      IAG_CLS_DIS_SVC = 4'b0001,
      IAG_CLS_EN_SVC = 4'b0010,
      IAG_CLS_REPEAT = 4'b0011,
      IAG_CLS_PUSHALL = 4'b0100,
      IAG_CLS_POPALL = 4'b0101,
      IAG_CLS_PUSHFLG = 4'b0110,
      IAG_CLS_POPFLG = 4'b0111,
      IAG_CLS_UNIMPL = 4'b1000,
      IAG_CLS_TRAP = 4'b1001
   } iag_cls_t;
endpackage

//--- logic/iag_gate.sv
// Purpose: Decide when pending interrupts may be acknowledged by the core.
// Assumes: Pipeline reports each completed instruction with a one-cycle pulse.
// Notes: Acknowledge happens only at instruction boundaries.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module iag_gate
   import iag_pkg::*;
#(
   parameter int NIRQ = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instr_done,
   input wire iag_cls_t instr_cls,
   input wire logic [15:0] pop_data,
   input wire logic flags_wr,
   input wire logic [IAG_NFLAGS-1:0] flags_in,
   input wire logic [NIRQ-1:0] irq_req,
   input wire logic nmi_req,
   output logic ack_valid,
   output logic ack_nmi,
   output logic [2:0] ack_idx,
   output logic direct_valid,
   output logic direct_trap,
   output logic [15:0] push_data,
   output logic push_valid,
   output logic [15:0] processor_status_word,
   output logic irq
);
   // ==========================================
   // Parameter check
   generate
      if (NIRQ != 8) begin : g_bad
         $error("NIRQ must equal the mask byte width of 8");
      end
   endgenerate

   // ==========================================
   // Helpers
   function automatic logic is_protected(input iag_cls_t c);
      case (c)
         IAG_CLS_DIS_SVC, IAG_CLS_EN_SVC, IAG_CLS_REPEAT, IAG_CLS_PUSHALL,
         IAG_CLS_POPALL, IAG_CLS_PUSHFLG, IAG_CLS_POPFLG: is_protected = 1'b1;
         default: is_protected = 1'b0;
      endcase
   endfunction

   // Highest index wins; stands in for the external priority ranking
   function automatic logic [2:0] top_idx(input logic [7:0] v);
      top_idx = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            top_idx = 3'(i);
         end
      end
   endfunction

   // ==========================================
   // State
   logic [15:0] stw_r, stw_nxt;
   logic [NIRQ-1:0] pend_r, pend_nxt;
   logic nmi_pend_r, nmi_pend_nxt;
   logic [IAG_NEVT-1:0] evt_stat_r, evt_stat_nxt;
   logic [IAG_NEVT-1:0] evt_mask_r, evt_mask_nxt;
   logic ack_valid_r, ack_valid_nxt;
   logic ack_nmi_r, ack_nmi_nxt;
   logic [2:0] ack_idx_r, ack_idx_nxt;
   logic direct_valid_r, direct_valid_nxt;
   logic direct_trap_r, direct_trap_nxt;
   logic [15:0] push_data_r, push_data_nxt;
   logic push_valid_r, push_valid_nxt;
   logic irq_r, irq_nxt;
   logic aw_full_r, aw_full_nxt;
   logic w_full_r, w_full_nxt;
   logic [3:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   // ==========================================
   // Next-state logic
   always_comb begin
      logic [NIRQ-1:0] elig;
      logic [NIRQ-1:0] pend_clr;
      logic nmi_clr;
      logic [IAG_NEVT-1:0] evt_set;
      logic [IAG_NEVT-1:0] evt_clr;
      logic [15:0] wmask;
      elig = '0;
      pend_clr = '0;
      nmi_clr = 1'b0;
      evt_set = '0;
      evt_clr = '0;
      wmask = 16'h0000;
      stw_nxt = stw_r;
      evt_mask_nxt = evt_mask_r;
      ack_valid_nxt = 1'b0;
      ack_nmi_nxt = ack_nmi_r;
      ack_idx_nxt = ack_idx_r;
      direct_valid_nxt = 1'b0;
      direct_trap_nxt = direct_trap_r;
      push_data_nxt = push_data_r;
      push_valid_nxt = 1'b0;
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;

      // Bus write: address and data taken in either order
      if (s_axi_awvalid && awready_r) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && wready_r) begin
         w_full_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (aw_full_r && w_full_r && !bvalid_r) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = IAG_RESP_OKAY;
         wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
         case (aw_addr_r)
            IAG_OFS_STW: begin
               stw_nxt = (stw_r & ~(wmask & IAG_STW_WMASK))
                  | (w_data_r[15:0] & wmask & IAG_STW_WMASK);
            end
            IAG_OFS_EVT_STAT: begin
               if (w_strb_r[0]) begin
                  evt_clr = w_data_r[IAG_NEVT-1:0];
               end
            end
            IAG_OFS_EVT_MASK: begin
               if (w_strb_r[0]) begin
                  evt_mask_nxt = w_data_r[IAG_NEVT-1:0];
               end
            end
            IAG_OFS_PEND: bresp_nxt = IAG_RESP_OKAY; // Read-only, write ignored
            default: begin
               bresp_nxt = IAG_RESP_SLVERR;
            end
         endcase
      end

      // Bus read
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = IAG_RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         case (s_axi_araddr[3:0])
            IAG_OFS_STW: rdata_nxt = {16'h0000, stw_r};
            IAG_OFS_PEND: rdata_nxt = {23'h000000, nmi_pend_r, pend_r};
            IAG_OFS_EVT_STAT: rdata_nxt = {29'h00000000, evt_stat_r};
            IAG_OFS_EVT_MASK: rdata_nxt = {29'h00000000, evt_mask_r};
            default: rresp_nxt = IAG_RESP_SLVERR;
         endcase
      end

      // Program flags from the execution unit
      if (flags_wr) begin
         stw_nxt[IAG_FLAG_LSB +: IAG_NFLAGS] = flags_in;
      end

      // Maskable sources need their mask bit and the global enable
      elig = pend_r & stw_r[7:0] & {NIRQ{stw_r[IAG_GIE_BIT]}};

      // Instruction boundary: pipeline effects take priority over the bus
      if (instr_done) begin
         case (instr_cls)
            IAG_CLS_DIS_SVC: stw_nxt[IAG_GIE_BIT] = 1'b0;
            IAG_CLS_EN_SVC: stw_nxt[IAG_GIE_BIT] = 1'b1;
            IAG_CLS_PUSHALL: begin
               push_data_nxt = stw_r;
               push_valid_nxt = 1'b1;
            end
            IAG_CLS_POPALL: stw_nxt = pop_data & IAG_STW_WMASK;
            IAG_CLS_PUSHFLG: begin
               push_data_nxt = {stw_r[15:8], 8'h00};
               push_valid_nxt = 1'b1;
            end
            IAG_CLS_POPFLG: begin
               stw_nxt[15:8] = pop_data[15:8] & IAG_STW_WMASK[15:8];
            end
            default: ;
         endcase
         if (instr_cls == IAG_CLS_UNIMPL || instr_cls == IAG_CLS_TRAP) begin
            // Straight to the handler, no ranking, no mask, no enable
            direct_valid_nxt = 1'b1;
            direct_trap_nxt = (instr_cls == IAG_CLS_TRAP);
            evt_set[IAG_EVT_DIRECT] = 1'b1;
         end else if (!is_protected(instr_cls)) begin
            if (nmi_pend_r) begin
               // Not gated by mask or enable
               ack_valid_nxt = 1'b1;
               ack_nmi_nxt = 1'b1;
               ack_idx_nxt = 3'h0;
               nmi_clr = 1'b1;
               evt_set[IAG_EVT_NACK] = 1'b1;
            end else if (|elig) begin
               ack_valid_nxt = 1'b1;
               ack_nmi_nxt = 1'b0;
               ack_idx_nxt = top_idx(elig);
               pend_clr[top_idx(elig)] = 1'b1;
               evt_set[IAG_EVT_MACK] = 1'b1;
            end
         end
      end

      // Requests held until served; a new request beats its own clear
      pend_nxt = (pend_r & ~pend_clr) | irq_req;
      nmi_pend_nxt = (nmi_pend_r & ~nmi_clr) | nmi_req;
      evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
      irq_nxt = |(evt_stat_nxt & evt_mask_nxt);

      // Ready only while the holding slot is free
      awready_nxt = !aw_full_nxt;
      wready_nxt = !w_full_nxt;
      arready_nxt = !rvalid_nxt;
   end

   // ==========================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stw_r <= IAG_STW_RST;
         pend_r <= '0;
         nmi_pend_r <= 1'b0;
         evt_stat_r <= '0;
         evt_mask_r <= '0;
         ack_valid_r <= 1'b0;
         ack_nmi_r <= 1'b0;
         ack_idx_r <= 3'h0;
         direct_valid_r <= 1'b0;
         direct_trap_r <= 1'b0;
         push_data_r <= 16'h0000;
         push_valid_r <= 1'b0;
         irq_r <= 1'b0;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= IAG_RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= IAG_RESP_OKAY;
      end else begin
         stw_r <= stw_nxt;
         pend_r <= pend_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         evt_stat_r <= evt_stat_nxt;
         evt_mask_r <= evt_mask_nxt;
         ack_valid_r <= ack_valid_nxt;
         ack_nmi_r <= ack_nmi_nxt;
         ack_idx_r <= ack_idx_nxt;
         direct_valid_r <= direct_valid_nxt;
         direct_trap_r <= direct_trap_nxt;
         push_data_r <= push_data_nxt;
         push_valid_r <= push_valid_nxt;
         irq_r <= irq_nxt;
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign ack_valid = ack_valid_r;
   assign ack_nmi = ack_nmi_r;
   assign ack_idx = ack_idx_r;
   assign direct_valid = direct_valid_r;
   assign direct_trap = direct_trap_r;
   assign push_data = push_data_r;
   assign push_valid = push_valid_r;
   assign processor_status_word = stw_r;
   assign irq = irq_r;
endmodule
`default_nettype wire

//--- verif/iag_gate_sva.sv
// Purpose: Port-level checks for the interrupt acceptance gate.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to the gate from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module iag_gate_sva
   import iag_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic instr_done,
   input wire iag_cls_t instr_cls,
   input wire logic ack_valid,
   input wire logic ack_nmi,
   input wire logic [2:0] ack_idx,
   input wire logic direct_valid,
   input wire logic direct_trap,
   input wire logic [15:0] push_data,
   input wire logic push_valid,
   input wire logic [15:0] processor_status_word
);
   // ==========================================
   // Status word as the gate saw it at the boundary
   logic [15:0] sw_r;
   logic [15:0] sw_nxt;
   always_comb begin
      sw_nxt = processor_status_word;
   end
   always_ff @(posedge aclk) begin
      sw_r <= sw_nxt;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_done(logic [3:0] c);
      instr_done && instr_cls == c;
   endsequence
   sequence s_prot;
      instr_done && instr_cls >= 4'h1 && instr_cls <= 4'h7;
   endsequence
   // ==========================================
   // Assertions
   a_direct_unimpl: assert property (s_done(4'h8) |=> direct_valid && !direct_trap)
      else $error("unimplemented opcode not vectored");
   a_direct_trap: assert property (s_done(4'h9) |=> direct_valid && direct_trap)
      else $error("trap not vectored");
   a_hold_protect: assert property (s_prot |=> !ack_valid)
      else $error("ack at protected boundary");
   a_ack_boundary: assert property (ack_valid |-> $past(instr_done))
      else $error("ack away from a boundary");
   a_mask_gate: assert property (ack_valid && !ack_nmi |-> sw_r[15] && sw_r[ack_idx])
      else $error("masked source acknowledged");
   a_resv_zero: assert property (processor_status_word[14] == 1'b0)
      else $error("reserved status bit set");
   a_push_whole: assert property (s_done(4'h4) |=> push_valid && push_data == sw_r)
      else $error("push-all word wrong");
   a_push_status: assert property (s_done(4'h6) |=> push_valid && push_data == {sw_r[15:8], 8'h00})
      else $error("push-flags word wrong");
endmodule
`default_nettype wire

//--- verif/iag_pipe_model.sv
// Purpose: Instruction pipeline stand-in feeding completed instructions.
// Assumes: Gate answers one cycle after the boundary.
// Notes: Pop word is scrambled once taken, as real stack data would be.
`timescale 1ns/10ps
`default_nettype none
module iag_pipe_model
   import iag_pkg::*;
(
   input wire logic aclk,
   output logic instr_done,
   output iag_cls_t instr_cls,
   output logic [15:0] pop_data,
   input wire logic ack_valid,
   input wire logic ack_nmi,
   input wire logic [2:0] ack_idx,
   input wire logic direct_valid,
   input wire logic direct_trap,
   input wire logic push_valid
);
   initial begin
      instr_done = 1'b0;
      instr_cls = IAG_CLS_PLAIN;
      pop_data = 16'h0000;
   end
   // Event byte: ack, nmi, idx, direct, trap, push
   task automatic issue(input logic [3:0] c, input logic [15:0] p, output logic [7:0] ev);
      @(posedge aclk);
      instr_done <= 1'b1;
      instr_cls <= iag_cls_t'(c);
      pop_data <= p;
      @(posedge aclk);
      instr_done <= 1'b0;
      pop_data <= ~p;
      @(negedge aclk);
      ev = {ack_valid, ack_nmi, ack_idx, direct_valid, direct_trap, push_valid};
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the interrupt acceptance gate.
// Assumes: Register slave answers within a few cycles.
// Notes: Register reads sample at the falling edge to dodge races.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import iag_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, instr_done, flags_wr, nmi_req, ack_valid, ack_nmi, direct_valid;
   logic direct_trap, push_valid, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   iag_cls_t instr_cls;
   logic [15:0] pop_data, push_data, processor_status_word;
   logic [5:0] flags_in;
   logic [7:0] irq_req;
   logic [2:0] ack_idx;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   iag_gate #(.NIRQ(8)) i_iag_gate (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .instr_done, .instr_cls, .pop_data, .flags_wr, .flags_in, .irq_req, .nmi_req,
      .ack_valid, .ack_nmi, .ack_idx, .direct_valid, .direct_trap, .push_data,
      .push_valid, .processor_status_word, .irq);
   iag_pipe_model i_iag_pipe_model (.aclk, .instr_done, .instr_cls, .pop_data,
      .ack_valid, .ack_nmi, .ack_idx, .direct_valid, .direct_trap, .push_valid);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic wrap_up;
      if (num_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic w(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er = 2'b00);
      logic pa;
      logic pw;
      logic ok;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge aclk);
         if (!pa) s_axi_awvalid <= 1'b0;
         if (!pw) s_axi_wvalid <= 1'b0;
      end
      do begin
         @(negedge aclk);
         ok = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end while (!ok);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
      logic ok;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ok = s_axi_arready;
         @(posedge aclk);
      end while (!ok);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         ok = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!ok);
      s_axi_rready <= 1'b0;
      chk($sformatf("reg %h", a), e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask
   task automatic run(input logic [3:0] c, input logic [15:0] p, input logic [7:0] e, m);
      logic [7:0] ev;
      i_iag_pipe_model.issue(c, p, ev);
      chk($sformatf("event cls %h", c), {24'h0, e}, {24'h0, ev & m});
   endtask
   task automatic pulse(input logic [8:0] v);
      @(posedge aclk);
      {nmi_req, irq_req} <= v;
      @(posedge aclk);
      {nmi_req, irq_req} <= 9'h000;
   endtask
   task automatic ci(input logic e);
      repeat (2) @(negedge aclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // ==========================================
   // Main sequence
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      {flags_wr, flags_in, nmi_req, irq_req} = 16'h0000;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(4'h0, 32'h0);
      rc(4'hc, 32'h0);
      w(4'h0, 16'h00ff);
      pulse(9'h008);
      run(4'h0, 16'h0, 8'h00, 8'h85);
      rc(4'h4, 32'h8);
      w(4'h0, 16'h8000);
      run(4'h0, 16'h0, 8'h00, 8'h85);
      w(4'h0, 16'h8008);
      run(4'h0, 16'h0, 8'h98, 8'hfd);
      w(4'h0, 16'h0000);
      for (int c = 1; c < 3; c++) begin
         pulse(9'h100);
         run(4'(c), 16'h0, 8'h00, 8'h85);
         run(4'h0, 16'h0, 8'hc0, 8'hc5);
      end
      rc(4'h0, 32'h8000);
      run(4'h8, 16'h0, 8'h04, 8'h87);
      run(4'h9, 16'h0, 8'h06, 8'h87);
      w(4'h0, 16'h8080);
      for (int c = 2; c < 8; c++) begin
         pulse(9'h080);
         run(4'(c), 16'h8080, {7'h0, c == 4 || c == 6}, 8'h85);
         run(4'h0, 16'h0, 8'hb8, 8'hfd);
      end
      w(4'h0, 16'h8055);
      run(4'h7, 16'h01aa, 8'h00, 8'h85);
      rc(4'h0, 32'h0155);
      run(4'h5, 16'h8a3c, 8'h00, 8'h85);
      rc(4'h0, 32'h8a3c);
      @(posedge aclk);
      flags_in <= 6'h15;
      flags_wr <= 1'b1;
      @(posedge aclk);
      flags_wr <= 1'b0;
      rc(4'h0, 32'h953c);
      // High byte only; reserved bit must stay clear
      s_axi_wstrb <= 4'h2;
      w(4'h0, 16'hffff);
      s_axi_wstrb <= 4'hf;
      rc(4'h0, 32'hbf3c);
      // Every event kind has fired by now
      rc(4'h8, 32'h7);
      w(4'hc, 16'h0007);
      ci(1'b1);
      w(4'hc, 16'h0000);
      ci(1'b0);
      w(4'hc, 16'h0007);
      w(4'h8, 16'h0007);
      rc(4'h8, 32'h0);
      ci(1'b0);
      w(4'h6, 16'h0000, IAG_RESP_SLVERR);
      w(4'h4, 16'h00ff);
      rc(4'h4, 32'h0);
      rc(4'h2, 32'h0, IAG_RESP_SLVERR);
      wrap_up();
   end
endmodule
bind iag_gate iag_gate_sva i_iag_gate_sva (.aclk, .aresetn, .instr_done, .instr_cls,
   .ack_valid, .ack_nmi, .ack_idx, .direct_valid, .direct_trap, .push_data,
   .push_valid, .processor_status_word);
`default_nettype wire
